/* File: hw/lai_code_qualifier.sv */
//----------------------------------------------------------------------
// Purpose: Qualifies a loopback code match for a programmable time
// Assumes: i_match is a same-clock level from the code detector
// Notes:   Status follows the match level once qualified
//----------------------------------------------------------------------
`timescale 1ns/1ps
module lai_code_qualifier
    import lai_pkg::*;
#(
    parameter int CW = LAI_QUAL_CW
) (
    input  wire logic          i_clk,    // Master clock
    input  wire logic          i_resetn, // Async reset, low
    input  wire logic          i_match,  // Code seen, error rate ok
    input  wire logic [CW-1:0] i_limit,  // Qualifying cycles
    output logic               o_status  // Qualified code status
);

    logic [CW-1:0] cnt_q;
    logic          status_q;

    // Saturates so a shortened limit still qualifies at once
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= '0;
        end else if (!i_match) begin
            cnt_q <= '0;
        end else if (cnt_q < i_limit) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Bit errors below threshold keep i_match high, so status holds
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_q <= 1'b0;
        end else begin
            status_q <= i_match && (cnt_q >= i_limit);
        end
    end

    assign o_status = status_q;

endmodule

/* File: hw/lai_edge_event.sv */
//----------------------------------------------------------------------
// Purpose: Turns status changes into gated one-cycle event pulses
// Assumes: Status comes from registers on the same clock
// Notes:   Reset value of the history matches status reset value
//----------------------------------------------------------------------
`timescale 1ns/1ps
module lai_edge_event #(
    parameter int W = 7
) (
    input  wire logic         i_clk,      // Master clock
    input  wire logic         i_resetn,   // Async reset, low
    input  wire logic [W-1:0] i_status,   // Current status bits
    input  wire logic [W-1:0] i_edge_sel, // 0 rise only, 1 any change
    input  wire logic [W-1:0] i_enable,   // Per source enable
    output logic      [W-1:0] o_event     // Gated event pulses
);

    logic [W-1:0] prev_q;
    logic [W-1:0] event_q;
    logic [W-1:0] rise;
    logic [W-1:0] change;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_q <= '0;
        end else begin
            prev_q <= i_status;
        end
    end

    assign rise   = i_status & ~prev_q;
    assign change = i_status ^ prev_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            event_q <= '0;
        end else begin
            event_q <= i_enable & ((i_edge_sel & change)
                                 | (~i_edge_sel & rise));
        end
    end

    assign o_event = event_q;

endmodule

/* File: hw/lai_pkg.sv */
//----------------------------------------------------------------------
// Purpose: Constants shared by the line alarm interrupt logic
// Assumes: Master clock is i_clk at 125 MHz
// Notes:   Register indices are word indices; byte address is 4x
//----------------------------------------------------------------------
package lai_pkg;

    //------------------------------------------------------------------
    // Clock and timing
    //------------------------------------------------------------------
    localparam longint LAI_CLK_KHZ        = 125000;
    localparam longint LAI_SHORT_QUAL_MS  = 40;
    localparam longint LAI_LONG_QUAL_MS   = 5100;
    localparam longint LAI_SHORT_QUAL_CYC = LAI_SHORT_QUAL_MS * LAI_CLK_KHZ;
    localparam longint LAI_LONG_QUAL_CYC  = LAI_LONG_QUAL_MS * LAI_CLK_KHZ;
    localparam int     LAI_QUAL_CW        = 30;
    localparam int     LAI_TCLK_LOSS_CYC  = 70;
    localparam int     LAI_TCLK_CW        = 7;

    //------------------------------------------------------------------
    // Register word indices
    //------------------------------------------------------------------
    localparam logic [5:0] LAI_IDX_ENABLE2 = 6'h34;
    localparam logic [5:0] LAI_IDX_EDGE    = 6'h35;
    localparam logic [5:0] LAI_IDX_STATUS  = 6'h36;
    localparam logic [5:0] LAI_IDX_CTRL    = 6'h3f;

    //------------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------------
    localparam int LAI_BIT_LOOP   = 7;
    localparam int LAI_BIT_ACT    = 6;
    localparam int LAI_BIT_DEACT  = 5;
    localparam int LAI_BIT_SYNC   = 4;
    localparam int LAI_BIT_TCLK   = 3;
    localparam int LAI_BIT_DF     = 2;
    localparam int LAI_BIT_AIS    = 1;
    localparam int LAI_BIT_LOS    = 0;
    localparam int LAI_BIT_CONV   = 6;
    localparam int LAI_BIT_TXJA   = 5;
    localparam int LAI_BIT_RXJA   = 4;
    localparam int LAI_BIT_PATERR = 3;
    localparam int LAI_BIT_EXZ    = 2;
    localparam int LAI_BIT_CV     = 1;
    localparam int LAI_BIT_CNT    = 0;
    localparam int LAI_BIT_AUTO   = 0;

    //------------------------------------------------------------------
    // Reset values and writable masks
    //------------------------------------------------------------------
    localparam logic [7:0] LAI_ENABLE2_RST  = 8'h00;
    localparam logic [7:0] LAI_EDGE_RST     = 8'h00;
    localparam logic [7:0] LAI_STATUS_RST   = 8'h00;
    localparam logic [7:0] LAI_CTRL_RST     = 8'h00;
    localparam logic [7:0] LAI_ENABLE2_MASK = 8'h7f;
    localparam logic [7:0] LAI_EDGE_MASK    = 8'h7f;
    localparam logic [7:0] LAI_CTRL_MASK    = 8'h01;

    typedef enum logic [0:0] {
        LAI_LOOP_OPEN   = 1'b0,
        LAI_LOOP_CLOSED = 1'b1
    } lai_loop_type;

endpackage

/* File: hw/lai_top.sv */
//----------------------------------------------------------------------
// Purpose: Per-channel line alarm interrupt and real-time status logic
// Assumes: APB slave, 125 MHz master clock, detectors outside
// Notes:   Event outputs are gated pulses; no latching here
//----------------------------------------------------------------------
// Functional notes
// - Second enable bit 6 gates converter overflow; resets 0; bit 7 reads 0.
// - Second enable bit 5 gates transmit jitter buffer slip; resets 0.
// - Second enable bit 4 gates receive jitter buffer slip; resets 0.
// - Second enable bit 3 gates test pattern logic error; resets 0.
// - Second enable bit 2 gates excess zeros event; resets 0.
// - Second enable bit 1 gates code violation event; resets 0.
// - Second enable bit 0 gates error counter overflow; resets 0.
// - Edge select 0 means rising change only, 1 means any change.
// - Edge bits 6..0 map activate, deactivate, sync, clock, driver, alarm, loss.
// - Event raised only with enable set and matching status change.
// - With auto loop on, activate code for 5.1 s closes loop.
// - With auto loop on, deactivate code for 5.1 s opens loop.
// - Code status bits set after 40 ms, or 5.1 s with auto loop.
// - Code status holds through bit errors below ten to minus two.
// - With auto loop on, activate status rise closes loop; deactivate status rise opens it.
// - Bit 4 shows live pattern sync, sequence chosen by line mode.
// - Bit 3 set when transmit clock idle over 70 master cycles.
// - Status register read-only, live, resets to zero.
// - Bit 2 shows driver short circuit, zero when normal.
// - Bit 1 shows alarm indication, bit 0 shows signal loss.
//----------------------------------------------------------------------
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module lai_top
    import lai_pkg::*;
#(
    parameter longint SHORT_QUAL_CYC = LAI_SHORT_QUAL_CYC,
    parameter longint LONG_QUAL_CYC  = LAI_LONG_QUAL_CYC
) (
    input  wire logic        i_clk,          // Master clock 125 MHz
    input  wire logic        i_resetn,       // Async reset, low
    input  wire logic [7:0]  i_paddr,        // APB byte address
    input  wire logic        i_psel,         // APB select
    input  wire logic        i_penable,      // APB enable
    input  wire logic        i_pwrite,       // APB write
    input  wire logic [31:0] i_pwdata,       // APB write data
    input  wire logic [3:0]  i_pstrb,        // APB byte strobes
    output logic      [31:0] o_prdata,       // APB read data
    output logic             o_pready,       // APB ready
    output logic             o_pslverr,      // APB error
    input  wire logic [6:0]  i_enable_first, // First enable reg bits
    input  wire logic        i_act_match,    // Activate code seen
    input  wire logic        i_deact_match,  // Deactivate code seen
    input  wire logic        i_pattern_sync, // Pattern detector locked
    input  wire logic        i_channel_tx_clock, // Transmit clock pin
    input  wire logic        i_driver_short, // Driver short detected
    input  wire logic        i_alarm_ind,    // Alarm indication seen
    input  wire logic        i_signal_loss,  // Receive signal lost
    input  wire logic [6:0]  i_err_event,    // Error event pulses
    output logic      [6:0]  o_status_event, // Gated status events
    output logic      [6:0]  o_err_event,    // Gated error events
    output logic             o_remote_loop,  // Remote loop closed
    output logic      [7:0]  o_line_status   // Live status copy
);

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    localparam int QCW = LAI_QUAL_CW;

    function automatic logic lai_hit(input logic [7:0] addr,
                                     input logic [5:0] idx);
        lai_hit = (addr == {idx, 2'b00});
    endfunction

    function automatic logic [QCW-1:0] lai_cyc(input longint c);
        lai_cyc = QCW'(c);
    endfunction

    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    logic [7:0]   enable2_q;
    logic [7:0]   edge_q;
    logic [7:0]   ctrl_q;
    logic [7:0]   status_q;
    logic [7:0]   status_d;
    logic [31:0]  prdata_q;
    logic         pslverr_q;
    logic         setup;
    logic         access;
    logic         wr_en;
    logic         hit_en2;
    logic         hit_edge;
    logic         hit_stat;
    logic         hit_ctrl;
    logic         mapped;
    logic [7:0]   rd_byte;
    logic         auto_on;
    logic [QCW-1:0] qual_limit;
    logic         act_status;
    logic         deact_status;
    logic         act_prev_q;
    logic         deact_prev_q;
    logic         act_rise;
    logic         deact_rise;
    lai_loop_type loop_q;
    lai_loop_type loop_d;
    logic [2:0]   tclk_sync_q;
    logic         tclk_level_q;
    logic         tclk_toggle;
    logic [LAI_TCLK_CW-1:0] idle_cnt_q;
    logic         tclk_missing;
    logic [6:0]   err_event_q;
    logic [6:0]   status_event;

    //------------------------------------------------------------------
    // APB decode
    //------------------------------------------------------------------
    assign setup    = i_psel && !i_penable;
    assign access   = i_psel && i_penable;
    assign hit_en2  = lai_hit(i_paddr, LAI_IDX_ENABLE2);
    assign hit_edge = lai_hit(i_paddr, LAI_IDX_EDGE);
    assign hit_stat = lai_hit(i_paddr, LAI_IDX_STATUS);
    assign hit_ctrl = lai_hit(i_paddr, LAI_IDX_CTRL);
    assign mapped   = hit_en2 || hit_edge || hit_stat || hit_ctrl;
    // Writes land only at the access edge, low byte lane only
    assign wr_en    = access && i_pwrite && i_pstrb[0];

    always_comb begin
        rd_byte = 8'h00;
        case (1'b1)
            hit_en2:  rd_byte = enable2_q & LAI_ENABLE2_MASK;
            hit_edge: rd_byte = edge_q & LAI_EDGE_MASK;
            hit_stat: rd_byte = status_q;
            hit_ctrl: rd_byte = ctrl_q & LAI_CTRL_MASK;
            default:  rd_byte = 8'h00;
        endcase
    end

    // Read data and error are captured in setup so access answers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            // Writing the live status register is refused
            pslverr_q <= !mapped || (i_pwrite && hit_stat);
        end
    end

    assign o_prdata  = prdata_q;
    assign o_pready  = 1'b1;
    assign o_pslverr = access && pslverr_q;

    //------------------------------------------------------------------
    // Software registers
    //------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            enable2_q <= LAI_ENABLE2_RST;
        end else if (wr_en && hit_en2) begin
            enable2_q <= i_pwdata[7:0] & LAI_ENABLE2_MASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            edge_q <= LAI_EDGE_RST;
        end else if (wr_en && hit_edge) begin
            edge_q <= i_pwdata[7:0] & LAI_EDGE_MASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= LAI_CTRL_RST;
        end else if (wr_en && hit_ctrl) begin
            ctrl_q <= i_pwdata[7:0] & LAI_CTRL_MASK;
        end
    end

    assign auto_on = ctrl_q[LAI_BIT_AUTO];

    //------------------------------------------------------------------
    // Loopback code qualification
    //------------------------------------------------------------------
    // Long window only while the loop is under automatic control
    assign qual_limit = auto_on ? lai_cyc(LONG_QUAL_CYC)
                                : lai_cyc(SHORT_QUAL_CYC);

    lai_code_qualifier #(
        .CW       (QCW)
    ) u_act_qual (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_match  (i_act_match),
        .i_limit  (qual_limit),
        .o_status (act_status)
    );

    lai_code_qualifier #(
        .CW       (QCW)
    ) u_deact_qual (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_match  (i_deact_match),
        .i_limit  (qual_limit),
        .o_status (deact_status)
    );

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            act_prev_q   <= 1'b0;
            deact_prev_q <= 1'b0;
        end else begin
            act_prev_q   <= act_status;
            deact_prev_q <= deact_status;
        end
    end

    assign act_rise   = act_status && !act_prev_q;
    assign deact_rise = deact_status && !deact_prev_q;

    //------------------------------------------------------------------
    // Automatic remote loop state
    //------------------------------------------------------------------
    // Deactivate wins if both rise together; opening is the safe side
    always_comb begin
        loop_d = loop_q;
        case (loop_q)
            LAI_LOOP_OPEN: begin
                if (auto_on && act_rise && !deact_rise) begin
                    loop_d = LAI_LOOP_CLOSED;
                end
            end
            LAI_LOOP_CLOSED: begin
                if (!auto_on || deact_rise) begin
                    loop_d = LAI_LOOP_OPEN;
                end
            end
            default: loop_d = LAI_LOOP_OPEN;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            loop_q <= LAI_LOOP_OPEN;
        end else begin
            loop_q <= loop_d;
        end
    end

    assign o_remote_loop = (loop_q == LAI_LOOP_CLOSED);

    //------------------------------------------------------------------
    // Transmit clock loss monitor
    //------------------------------------------------------------------
    // Clock pin is asynchronous: three stages, accept when 2 and 3 agree
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tclk_sync_q <= 3'h0;
        end else begin
            tclk_sync_q <= {tclk_sync_q[1:0], i_channel_tx_clock};
        end
    end

    assign tclk_toggle = (tclk_sync_q[1] == tclk_sync_q[2])
                      && (tclk_sync_q[2] != tclk_level_q);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tclk_level_q <= 1'b0;
        end else if (tclk_toggle) begin
            tclk_level_q <= tclk_sync_q[2];
        end
    end

    // Counter saturates one past the limit to flag the loss
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            idle_cnt_q <= '0;
        end else if (tclk_toggle) begin
            idle_cnt_q <= '0;
        end else if (idle_cnt_q <= LAI_TCLK_CW'(LAI_TCLK_LOSS_CYC)) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    assign tclk_missing = idle_cnt_q > LAI_TCLK_CW'(LAI_TCLK_LOSS_CYC);

    //------------------------------------------------------------------
    // Live status register
    //------------------------------------------------------------------
    always_comb begin
        status_d                = LAI_STATUS_RST;
        status_d[LAI_BIT_LOOP]  = o_remote_loop;
        status_d[LAI_BIT_ACT]   = act_status;
        status_d[LAI_BIT_DEACT] = deact_status;
        // Detector picks the sequence for the line mode
        status_d[LAI_BIT_SYNC]  = i_pattern_sync;
        status_d[LAI_BIT_TCLK]  = tclk_missing;
        status_d[LAI_BIT_DF]    = i_driver_short;
        status_d[LAI_BIT_AIS]   = i_alarm_ind;
        status_d[LAI_BIT_LOS]   = i_signal_loss;
    end

    // Live copy, not latched history
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_q <= LAI_STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    assign o_line_status = status_q;

    //------------------------------------------------------------------
    // Event generation
    //------------------------------------------------------------------
    // Edge and enable bit n both serve status bit n
    lai_edge_event #(
        .W          (7)
    ) u_status_evt (
        .i_clk      (i_clk),
        .i_resetn   (i_resetn),
        .i_status   (status_q[6:0]),
        .i_edge_sel (edge_q[6:0]),
        .i_enable   (i_enable_first),
        .o_event    (status_event)
    );

    assign o_status_event = status_event;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            err_event_q <= 7'h00;
        end else begin
            err_event_q <= i_err_event & enable2_q[6:0];
        end
    end

    assign o_err_event = err_event_q;

endmodule

/* File: verification/lai_chk.sv */
//--------------------
// Purpose: Port assertions for the line alarm interrupt logic
// Assumes: Sees only lai_top ports, one clock domain
// Notes:   Events are tied to their causes one cycle earlier
//--------------------
`timescale 1ns/1ps
module lai_chk (
    input wire logic        i_clk,              // Clock
    input wire logic        i_resetn,           // Reset, low
    input wire logic [7:0]  i_paddr,            // Address
    input wire logic        i_psel,             // Select
    input wire logic        i_penable,          // Enable
    input wire logic        i_pwrite,           // Write
    input wire logic [31:0] o_prdata,           // Read data
    input wire logic        o_pslverr,          // Error
    input wire logic [6:0]  i_enable_first,     // Status enables
    input wire logic        i_channel_tx_clock, // Tx clock pin
    input wire logic        i_signal_loss,      // Loss level
    input wire logic [6:0]  i_err_event,        // Error pulses in
    input wire logic [6:0]  o_status_event,     // Status events
    input wire logic [6:0]  o_err_event,        // Error events
    input wire logic        o_remote_loop,      // Loop closed
    input wire logic [7:0]  o_line_status       // Status copy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Cycles since the tx clock pin last changed
    logic       tck_q;
    logic [7:0] idle_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tck_q  <= 1'b0;
            idle_q <= 8'h00;
        end else begin
            tck_q <= i_channel_tx_clock;
            if (tck_q != i_channel_tx_clock) begin
                idle_q <= 8'h00;
            end else if (idle_q != 8'hff) begin
                idle_q <= idle_q + 8'h01;
            end
        end
    end

    property p_err_gate;
        (o_err_event & ~$past(i_err_event)) == 7'h00;
    endproperty
    a_err_gate: assert property (p_err_gate)
        else $error("error event without input pulse");
    property p_st_gate;
        (o_status_event & ~$past(i_enable_first)) == 7'h00;
    endproperty
    a_st_gate: assert property (p_st_gate)
        else $error("status event while masked");
    property p_ro;
        i_psel && i_penable && i_pwrite && i_paddr == 8'hd8 |-> o_pslverr;
    endproperty
    a_ro: assert property (p_ro)
        else $error("status write not refused");
    property p_rsv;
        i_psel && i_penable && !i_pwrite && i_paddr inside {8'hd0, 8'hd4}
            |-> o_prdata[31:7] == 25'h0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bits read nonzero");
    property p_loop_set;
        $rose(o_remote_loop) |-> ##[1:2] o_line_status[7];
    endproperty
    a_loop_set: assert property (p_loop_set)
        else $error("loop bit not set");
    property p_loop_clr;
        $fell(o_remote_loop) |-> ##[1:2] !o_line_status[7];
    endproperty
    a_loop_clr: assert property (p_loop_clr)
        else $error("loop bit not cleared");
    property p_los;
        $rose(i_signal_loss) |-> ##[1:2] o_line_status[0];
    endproperty
    a_los: assert property (p_los)
        else $error("loss status late");
    property p_tck;
        $rose(o_line_status[3]) |-> idle_q >= 8'd70;
    endproperty
    a_tck: assert property (p_tck)
        else $error("clock loss flagged early");
    property p_rst;
        $rose(i_resetn) |-> o_line_status == 8'h00;
    endproperty
    a_rst: assert property (p_rst)
        else $error("status not zero after reset");

    c_st: cover property (o_status_event != 7'h00);
    c_err: cover property (o_err_event != 7'h00);
    c_loop: cover property ($rose(o_remote_loop));
endmodule

/* File: verification/lai_top_tb.sv */
//--------------------
// Purpose: Self-checking bench for lai_top over APB
// Assumes: Short qualifying counts for simulation
// Notes:   Non-APB outputs sampled at falling edges, where settled, bar the status bit check right after the first watch of each pass
//--------------------
`timescale 1ns/1ps
module lai_top_tb;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [7:0]  i_paddr = 8'h00;
    logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [31:0] i_pwdata = 32'h0;
    logic [3:0]  i_pstrb = 4'hf;
    logic [6:0]  i_enable_first = 7'h77, i_err_event = 7'h00, lv = 7'h00;
    logic        i_channel_tx_clock = 1'b0;
    logic [31:0] o_prdata, r;
    logic        o_pready, o_pslverr, o_remote_loop;
    logic [6:0]  o_status_event, o_err_event;
    logic [7:0]  o_line_status;
    int          n_fail = 0, check_count = 0;
    int          srcs[4] = '{0, 1, 2, 4};

    always #4 i_clk = ~i_clk;

    lai_top #(.SHORT_QUAL_CYC(20), .LONG_QUAL_CYC(50)) u_lai_top (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_paddr(i_paddr),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_enable_first(i_enable_first), .i_act_match(lv[6]),
        .i_deact_match(lv[5]), .i_pattern_sync(lv[4]),
        .i_channel_tx_clock(i_channel_tx_clock),
        .i_driver_short(lv[2]), .i_alarm_ind(lv[1]),
        .i_signal_loss(lv[0]), .i_err_event(i_err_event),
        .o_status_event(o_status_event), .o_err_event(o_err_event),
        .o_remote_loop(o_remote_loop), .o_line_status(o_line_status));

    task give_verdict;
        if (n_fail == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
        end
    endtask

    // Waits on pready only; slave latency is not assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h0, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            give_verdict;
        end
        r = o_prdata;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(r, e);
    endtask

    task automatic watch(input logic [6:0] e);
        logic [6:0] acc;
        acc = 7'h00;
        repeat (5) begin
            @(negedge i_clk);
            acc |= o_status_event;
        end
        chk({25'h0, acc}, {25'h0, e});
        @(posedge i_clk);
    endtask

    task automatic st(input int b, input logic e);
        @(negedge i_clk);
        chk({31'h0, o_line_status[b]}, {31'h0, e});
    endtask

    initial begin
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(8'hd0, 32'h0);
        rd(8'hd4, 32'h0);
        rd(8'hd8, 32'h0);
        rd(8'h00, 32'h0);
        wr(8'hd0, 8'hff);
        rd(8'hd0, 32'h7f);
        wr(8'hd4, 8'hff);
        rd(8'hd4, 32'h7f);
        wr(8'hd8, 8'hff);
        i_pstrb <= 4'h0;
        wr(8'hd0, 8'h00);
        i_pstrb <= 4'hf;
        rd(8'hd0, 32'h7f);
        for (int k = 0; k < 7; k++) begin
            wr(8'hd0, 8'h01 << k);
            @(posedge i_clk) i_err_event <= 7'h7f;
            @(posedge i_clk) i_err_event <= 7'h00;
            @(negedge i_clk);
            chk({25'h0, o_err_event}, 32'h1 << k);
        end
        foreach (srcs[i]) for (int es = 0; es < 2; es++) begin
            wr(8'hd4, es ? 8'h01 << srcs[i] : 8'h00);
            lv[srcs[i]] <= 1'b1;
            watch(7'h01 << srcs[i]);
            chk({31'h0, o_line_status[srcs[i]]}, 32'h1);
            lv[srcs[i]] <= 1'b0;
            watch(es ? 7'h01 << srcs[i] : 7'h00);
        end
        i_enable_first <= 7'h00;
        lv[1] <= 1'b1;
        watch(7'h00);
        i_enable_first <= 7'h7f;
        lv[1] <= 1'b0;
        // Toggle every second cycle so the synchroniser accepts it
        repeat (50) begin
            repeat (2) @(posedge i_clk);
            i_channel_tx_clock <= ~i_channel_tx_clock;
        end
        st(3, 1'b0);
        repeat (60) @(posedge i_clk);
        st(3, 1'b0);
        repeat (13) @(posedge i_clk);
        watch(7'h08);
        st(3, 1'b1);
        @(posedge i_clk) lv <= 7'h40;
        repeat (15) @(posedge i_clk);
        st(6, 1'b0);
        repeat (15) @(posedge i_clk);
        st(6, 1'b1);
        chk({31'h0, o_remote_loop}, 32'h0);
        @(posedge i_clk) lv <= 7'h00;
        wr(8'hfc, 8'h01);
        @(posedge i_clk) lv <= 7'h40;
        repeat (40) @(posedge i_clk);
        st(6, 1'b0);
        chk({31'h0, o_remote_loop}, 32'h0);
        repeat (25) @(posedge i_clk);
        st(7, 1'b1);
        chk({31'h0, o_remote_loop}, 32'h1);
        @(posedge i_clk) lv <= 7'h20;
        repeat (65) @(posedge i_clk);
        st(7, 1'b0);
        give_verdict;
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        give_verdict;
    end
endmodule

bind lai_top lai_chk u_lai_chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_paddr(i_paddr),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_enable_first(i_enable_first),
    .i_channel_tx_clock(i_channel_tx_clock),
    .i_signal_loss(i_signal_loss), .i_err_event(i_err_event),
    .o_status_event(o_status_event), .o_err_event(o_err_event),
    .o_remote_loop(o_remote_loop), .o_line_status(o_line_status));
